// [rtl/debug_action_unit.v]
// Debug action unit: event arbitration, debug actions, monitor trap entry and return.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "debug_action_defs.vh"
// Contract
// - trap saves link, status, A10, A11 words
// - trap loads A11, A10, link fields, PC
// - trap resets status fields, sets trap_active_flag
// - return restores context; no-op when debug off
// - no triggers from context save accesses
// - no fetch traps in monitor code region
// - no data traps in save area region
// - trap only when trap_active_flag clear
// - return or register write clears flag
// - reset sets flag; software must clear
// - up to four prioritised breakpoint interrupts
// - lower priority interrupt is posted as software
// - posting sets posted_event_flag
// - posting keeps halt signals, updates event_origin
// - breakpoint interrupt to this or another core
// - event drives suspend-out, records prior level
// - events start or stop counters; only trigger events toggle
// - None action still updates status and signals
// - Disabled action ignores event completely
// - suspend-in halts while debug is enabled
// - oldest pipeline instruction served first
// - fixed source priority, external event highest
module debug_action_unit #(
   parameter NUM_BPI = 4
) (
   input  wire        mclk_i,
   input  wire        rst_b_i,
   input  wire        hsel_i,
   input  wire [31:0] haddr_i,
   input  wire [1:0]  htrans_i,
   input  wire        hwrite_i,
   input  wire [2:0]  hsize_i,
   input  wire [31:0] hwdata_i,
   input  wire        hready_i,
   output wire        hreadyout_o,
   output wire        hresp_o,
   output reg  [31:0] hrdata_o,
   input  wire        monitor_mode_on_i,
   input  wire        ext_evt_i,
   input  wire        suspend_in_i,
   input  wire [7:0]  pc_trig_i,
   input  wire [7:0]  addr_trig_i,
   input  wire        addr_trig_older_i,
   input  wire        csa_entry_access_i,
   input  wire        creg_evt_i,
   input  wire        dbg_instr_i,
   input  wire        perf_task_mode_i,
   input  wire [7:0]  current_cpu_priority_i,
   input  wire        global_int_enable_i,
   input  wire [31:0] prev_context_link_i,
   input  wire [31:0] proc_status_word_i,
   input  wire [31:0] a10_i,
   input  wire [31:0] a11_i,
   input  wire [31:0] pc_i,
   input  wire [31:0] int_stack_ptr_i,
   input  wire        monitor_return_instr_i,
   input  wire [31:0] fetch_addr_i,
   input  wire [31:0] ls_addr_i,
   input  wire [31:0] mem_rdata_i,
   output reg         mem_we_o,
   output reg         mem_re_o,
   output reg  [31:0] mem_addr_o,
   output reg  [31:0] mem_wdata_o,
   output reg         ctx_load_o,
   output reg         ctx_is_trap_o,
   output reg  [31:0] ctx_prev_context_link_o,
   output reg  [31:0] ctx_psw_o,
   output reg  [31:0] ctx_a10_o,
   output reg  [31:0] ctx_a11_o,
   output reg  [31:0] ctx_pc_o,
   output wire        exec_protect_trap_off_o,
   output wire        read_protect_trap_off_o,
   output reg         bpi_req_o,
   output reg  [1:0]  bpi_num_o,
   output reg  [7:0]  bpi_prio_o,
   output reg         bpi_other_core_o,
   output reg         swint_post_o,
   output reg  [7:0]  swint_level_o,
   output wire        suspend_out_o,
   output reg         perf_run_o,
   output wire        halt_o,
   output wire        trap_active_o
);
   localparam ST_IDLE    = 2'h0;
   localparam ST_SAVE    = 2'h1;
   localparam ST_RESTORE = 2'h2;
   integer i;
   reg [31:0] mon_entry_reg;
   reg [31:0] ctx_save_reg;
   reg        trap_active_reg;
   reg [1:0]  halt_reg;
   reg        halt_signal_state_reg;
   reg        psusp_reg;
   reg        posted_event_flag_reg;
   reg [4:0]  event_origin_reg;
   reg [7:0]  evt_cfg_reg [0:10];
   reg [8:0]  bpi_ctrl_reg [0:NUM_BPI-1];
   reg        wr_pend_reg;
   reg [15:0] wr_addr_reg;
   reg        ext_s1_reg;
   reg        ext_s2_reg;
   reg        ext_old_reg;
   reg        sin_s1_reg;
   reg        sin_s2_reg;
   reg [1:0]  state_reg;
   reg [2:0]  cnt_reg;
   reg [31:0] snap_reg [0:3];

   wire       ext_pulse = ext_s2_reg & ~ext_old_reg;
   wire       addr_go   = hsel_i & htrans_i[1] & hready_i;
   wire [7:0] addr_v;
   reg        win_hit;
   reg [3:0]  win_idx;
   reg [31:0] rd_mux;
   reg [3:0]  cfg_idx;
   reg [3:0]  bpi_idx;

   // Words written by trap entry itself never trigger.
   assign addr_v = (csa_entry_access_i || state_reg != ST_IDLE) ? 8'h00 : addr_trig_i;

   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;
   assign suspend_out_o = halt_signal_state_reg;
   assign trap_active_o = trap_active_reg;
   assign halt_o = (halt_reg == `HALT_ENTER) | (monitor_mode_on_i & sin_s2_reg);
   assign exec_protect_trap_off_o = monitor_mode_on_i &
                                    (fetch_addr_i[31:24] == mon_entry_reg[31:24]);
   assign read_protect_trap_off_o = monitor_mode_on_i &
                                    (ls_addr_i[31:24] == ctx_save_reg[31:24]);

   // Oldest instruction first, then the fixed source order; the external event ranks highest.
   always @* begin
      win_hit = 1'b0;
      win_idx = 4'h0;
      if (addr_trig_older_i && (|addr_v)) begin
         win_hit = 1'b1;
         for (i = 7; i >= 0; i = i - 1)
            if (addr_v[i]) win_idx = i[3:0] + 4'h3;
      end else if (ext_pulse) begin
         win_hit = 1'b1;
         win_idx = 4'h0;
      end else if (|pc_trig_i) begin
         win_hit = 1'b1;
         for (i = 7; i >= 0; i = i - 1)
            if (pc_trig_i[i]) win_idx = i[3:0] + 4'h3;
      end else if (creg_evt_i) begin
         win_hit = 1'b1;
         win_idx = 4'h1;
      end else if (dbg_instr_i) begin
         win_hit = 1'b1;
         win_idx = 4'h2;
      end else if (|addr_v) begin
         win_hit = 1'b1;
         for (i = 7; i >= 0; i = i - 1)
            if (addr_v[i]) win_idx = i[3:0] + 4'h3;
      end
   end
   wire [7:0] win_cfg  = evt_cfg_reg[win_idx];
   wire [2:0] win_act  = win_cfg[2:0];
   wire       win_is_bpi = win_act[2];
   wire [1:0] win_bpi  = win_act[1:0];
   wire       bpi_ok   = ({1'b0, win_bpi} < NUM_BPI[2:0]);
   wire [8:0] win_bctl = bpi_ok ? bpi_ctrl_reg[win_bpi] : 9'h000;
   wire       evt_on   = win_hit & (win_act != `ACT_DISABLED);
   wire       posted   = evt_on & win_is_bpi & bpi_ok & ~win_bctl[`BPI_OTHER] &
                         (win_bctl[7:0] < current_cpu_priority_i);
   wire [3:0] idx_m3   = win_idx - 4'h3;
   wire [4:0] win_src  = (win_idx < 4'h3) ? {1'b0, win_idx} : (`EVENT_ORIGIN_TRIG | {2'b00, idx_m3[2:0]});
   wire [1:0] win_cnt  = win_cfg[`CFG_CNT_LO+1:`CFG_CNT_LO];
   wire       trap_go  = evt_on & (win_act == `ACT_TRAP) & ~trap_active_reg &
                         (state_reg == ST_IDLE);
   wire       rfm_go   = monitor_return_instr_i & monitor_mode_on_i &
                         (state_reg == ST_IDLE);

   function [3:0] cfg_of;
      input [15:0] a;
      begin
         cfg_of = 4'hF;
         if (a == `OFS_EXT_CFG) cfg_of = 4'h0;
         if (a == `OFS_CREG_CFG) cfg_of = 4'h1;
         if (a == `OFS_SWDBG_CFG) cfg_of = 4'h2;
         for (i = 0; i < 8; i = i + 1)
            if (a == `OFS_TRIG_CFG0 + i[15:0] * `TRIG_CFG_STEP) cfg_of = i[3:0] + 4'h3;
      end
   endfunction
   function [3:0] bpi_of;
      input [15:0] a;
      begin
         bpi_of = 4'hF;
         for (i = 0; i < NUM_BPI; i = i + 1)
            if (a == `OFS_BPI_CTRL0 - i[15:0] * `BPI_CTRL_STEP) bpi_of = i[3:0];
      end
   endfunction

   always @* begin
      cfg_idx = cfg_of(haddr_i[15:0]);
      bpi_idx = bpi_of(haddr_i[15:0]);
      rd_mux  = 32'h0000_0000;
      case (haddr_i[15:0])
         `OFS_DBGSTAT: begin
            rd_mux[`DBGSTAT_DE] = monitor_mode_on_i;
            rd_mux[`DBGSTAT_HALT_LO+1:`DBGSTAT_HALT_LO] = halt_reg;
            rd_mux[`DBGSTAT_SIH] = monitor_mode_on_i & sin_s2_reg;
            rd_mux[`DBGSTAT_HALT_SIGNAL_STATE] = halt_signal_state_reg;
            rd_mux[`DBGSTAT_PSUSP] = psusp_reg;
            rd_mux[`DBGSTAT_POSTED_EVENT_FLAG] = posted_event_flag_reg;
            rd_mux[`DBGSTAT_SRC_LO+4:`DBGSTAT_SRC_LO] = event_origin_reg;
         end
         `OFS_MON_ENTRY: rd_mux = mon_entry_reg;
         `OFS_CTX_SAVE:  rd_mux = ctx_save_reg;
         `OFS_TRAP_CTRL: rd_mux = {31'h0000_0000, trap_active_reg};
         default: begin
            if (cfg_idx != 4'hF) rd_mux = {24'h00_0000, evt_cfg_reg[cfg_idx]};
            else if (bpi_idx != 4'hF) rd_mux = {23'h00_0000, bpi_ctrl_reg[bpi_idx[1:0]]};
         end
      endcase
   end
   wire        wr_go   = wr_pend_reg;
   wire [3:0]  wr_cfg  = cfg_of(wr_addr_reg);
   wire [3:0]  wr_bpi  = bpi_of(wr_addr_reg);
   wire        wr_stat = wr_go & (wr_addr_reg == `OFS_DBGSTAT);
   wire [1:0]  wr_halt = hwdata_i[`DBGSTAT_HALT_LO+1:`DBGSTAT_HALT_LO];

   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         hrdata_o        <= 32'h0000_0000;
         wr_pend_reg     <= 1'b0;
         wr_addr_reg     <= 16'h0000;
         ext_s1_reg      <= 1'b0;
         ext_s2_reg      <= 1'b0;
         ext_old_reg     <= 1'b0;
         sin_s1_reg      <= 1'b0;
         sin_s2_reg      <= 1'b0;
         mon_entry_reg   <= 32'h0000_0000;
         ctx_save_reg    <= 32'h0000_0000;
         trap_active_reg <= `DTA_RESET;
         halt_reg        <= 2'h0;
         halt_signal_state_reg        <= 1'b0;
         psusp_reg       <= 1'b0;
         posted_event_flag_reg        <= 1'b0;
         event_origin_reg      <= 5'h00;
         perf_run_o      <= 1'b0;
         bpi_req_o       <= 1'b0;
         bpi_num_o       <= 2'h0;
         bpi_prio_o      <= 8'h00;
         bpi_other_core_o <= 1'b0;
         swint_post_o    <= 1'b0;
         swint_level_o   <= 8'h00;
         for (i = 0; i < 11; i = i + 1)
            evt_cfg_reg[i] <= 8'h00;
         for (i = 0; i < NUM_BPI; i = i + 1)
            bpi_ctrl_reg[i] <= 9'h000;
      end else begin
         ext_s1_reg  <= ext_evt_i;
         ext_s2_reg  <= ext_s1_reg;
         ext_old_reg <= ext_s2_reg;
         sin_s1_reg  <= suspend_in_i;
         sin_s2_reg  <= sin_s1_reg;
         wr_pend_reg <= addr_go & hwrite_i;
         if (addr_go) begin
            wr_addr_reg <= haddr_i[15:0];
            if (!hwrite_i) hrdata_o <= rd_mux;
         end
         // Software writes; hardware updates below take precedence.
         if (wr_go && wr_addr_reg == `OFS_MON_ENTRY) mon_entry_reg <= hwdata_i;
         if (wr_go && wr_addr_reg == `OFS_CTX_SAVE) ctx_save_reg <= hwdata_i;
         if (wr_go && wr_addr_reg == `OFS_TRAP_CTRL) trap_active_reg <= hwdata_i[0];
         if (wr_go && wr_cfg != 4'hF) evt_cfg_reg[wr_cfg] <= hwdata_i[7:0];
         if (wr_go && wr_bpi != 4'hF) bpi_ctrl_reg[wr_bpi[1:0]] <= hwdata_i[8:0];
         if (wr_stat) begin
            halt_signal_state_reg <= hwdata_i[`DBGSTAT_HALT_SIGNAL_STATE];
            posted_event_flag_reg <= hwdata_i[`DBGSTAT_POSTED_EVENT_FLAG];
            if (wr_halt == `HALT_ENTER) begin
               halt_reg   <= `HALT_ENTER;
               event_origin_reg <= 5'h00;
            end else if (wr_halt == `HALT_LEAVE) begin
               halt_reg <= 2'h0;
            end
         end
         if (rfm_go) trap_active_reg <= 1'b0;
         if (trap_go) trap_active_reg <= 1'b1;
         bpi_req_o    <= 1'b0;
         swint_post_o <= 1'b0;
         if (evt_on) begin
            event_origin_reg <= win_src;
            if (posted) begin
               posted_event_flag_reg      <= 1'b1;
               swint_post_o  <= 1'b1;
               swint_level_o <= win_bctl[7:0];
            end else begin
               psusp_reg <= halt_signal_state_reg;
               halt_signal_state_reg  <= win_cfg[`CFG_HALT_SIGNAL_STATE];
            end
            if (perf_task_mode_i) begin
               if (win_cnt == `CNT_START) perf_run_o <= 1'b1;
               if (win_cnt == `CNT_STOP) perf_run_o <= 1'b0;
               if (win_cnt == `CNT_TOGGLE && win_idx >= 4'h3) perf_run_o <= ~perf_run_o;
            end
            if (win_act == `ACT_HALT) halt_reg <= `HALT_ENTER;
            if (win_is_bpi && bpi_ok && !posted) begin
               bpi_req_o        <= 1'b1;
               bpi_num_o        <= win_bpi;
               bpi_prio_o       <= win_bctl[7:0];
               bpi_other_core_o <= win_bctl[`BPI_OTHER];
            end
         end
      end
   end

   // Trap entry saves four words; return reads them back one cycle per read.
   always @(posedge mclk_i) begin
      if (!rst_b_i) begin
         state_reg     <= ST_IDLE;
         cnt_reg       <= 3'h0;
         mem_we_o      <= 1'b0;
         mem_re_o      <= 1'b0;
         mem_addr_o    <= 32'h0000_0000;
         mem_wdata_o   <= 32'h0000_0000;
         ctx_load_o    <= 1'b0;
         ctx_is_trap_o <= 1'b0;
         ctx_prev_context_link_o    <= 32'h0000_0000;
         ctx_psw_o     <= 32'h0000_0000;
         ctx_a10_o     <= 32'h0000_0000;
         ctx_a11_o     <= 32'h0000_0000;
         ctx_pc_o      <= 32'h0000_0000;
         for (i = 0; i < 4; i = i + 1)
            snap_reg[i] <= 32'h0000_0000;
      end else begin
         mem_we_o   <= 1'b0;
         mem_re_o   <= 1'b0;
         ctx_load_o <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               cnt_reg <= 3'h0;
               if (trap_go) begin
                  snap_reg[0] <= prev_context_link_i;
                  snap_reg[1] <= proc_status_word_i;
                  snap_reg[2] <= a10_i;
                  snap_reg[3] <= a11_i;
                  ctx_prev_context_link_o <= prev_context_link_i;
                  ctx_prev_context_link_o[`PREV_CONTEXT_LINK_PIE] <= global_int_enable_i;
                  ctx_prev_context_link_o[`PREV_CONTEXT_LINK_PRIOR_CPU_PRIORITY_LO+7:`PREV_CONTEXT_LINK_PRIOR_CPU_PRIORITY_LO] <= current_cpu_priority_i;
                  ctx_a11_o <= pc_i;
                  ctx_a10_o <= proc_status_word_i[`PSW_IS] ? a10_i : int_stack_ptr_i;
                  ctx_pc_o  <= mon_entry_reg;
                  ctx_psw_o <= proc_status_word_i;
                  ctx_psw_o[`PSW_PRS_LO+1:`PSW_PRS_LO] <= 2'h0;
                  ctx_psw_o[`PSW_IO_LO+1:`PSW_IO_LO] <= `PSW_IO_MONITOR;
                  ctx_psw_o[`PSW_GW]  <= 1'b0;
                  ctx_psw_o[`PSW_IS]  <= 1'b1;
                  ctx_psw_o[`PSW_CDE] <= 1'b0;
                  ctx_psw_o[6:0]      <= 7'h00;
                  ctx_is_trap_o <= 1'b1;
                  state_reg <= ST_SAVE;
               end else if (rfm_go) begin
                  ctx_is_trap_o <= 1'b0;
                  state_reg <= ST_RESTORE;
               end
            end
            ST_SAVE: begin
               mem_we_o    <= 1'b1;
               mem_addr_o  <= ctx_save_reg + {27'h000_0000, cnt_reg[1:0], 2'b00};
               mem_wdata_o <= snap_reg[cnt_reg[1:0]];
               cnt_reg     <= cnt_reg + 3'h1;
               if (cnt_reg == 3'h3) begin
                  ctx_load_o <= 1'b1;
                  state_reg  <= ST_IDLE;
               end
            end
            ST_RESTORE: begin
               if (cnt_reg < 3'h4) begin
                  mem_re_o   <= 1'b1;
                  mem_addr_o <= ctx_save_reg + {27'h000_0000, cnt_reg[1:0], 2'b00};
               end
               if (cnt_reg == 3'h2) ctx_prev_context_link_o <= mem_rdata_i;
               if (cnt_reg == 3'h3) ctx_psw_o <= mem_rdata_i;
               if (cnt_reg == 3'h4) ctx_a10_o <= mem_rdata_i;
               if (cnt_reg == 3'h5) begin
                  ctx_a11_o  <= mem_rdata_i;
                  ctx_pc_o   <= mem_rdata_i;
                  ctx_load_o <= 1'b1;
                  state_reg  <= ST_IDLE;
               end
               cnt_reg <= cnt_reg + 3'h1;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

endmodule
`default_nettype wire

// [rtl/debug_action_defs.vh]
// Constants for the debug action unit: offsets, fields, codes and reset values.
`ifndef DEBUG_ACTION_DEFS_VH
`define DEBUG_ACTION_DEFS_VH
`define OFS_DBGSTAT     16'hFD00
`define OFS_EXT_CFG     16'hFD08
`define OFS_CREG_CFG    16'hFD0C
`define OFS_SWDBG_CFG   16'hFD10
`define OFS_MON_ENTRY   16'hFD40
`define OFS_CTX_SAVE    16'hFD44
`define OFS_TRAP_CTRL   16'hFD48
`define OFS_TRIG_CFG0   16'hF000
`define TRIG_CFG_STEP   16'h0008
`define OFS_BPI_CTRL0   16'hFFBC
`define BPI_CTRL_STEP   16'h0004
`define DBGSTAT_DE      0
`define DBGSTAT_HALT_LO 1
`define DBGSTAT_SIH     3
`define DBGSTAT_HALT_SIGNAL_STATE    4
`define DBGSTAT_PSUSP   6
`define DBGSTAT_POSTED_EVENT_FLAG    7
`define DBGSTAT_SRC_LO  8
`define HALT_ENTER      2'h1
`define HALT_LEAVE      2'h2
`define ACT_DISABLED    3'h0
`define ACT_NONE        3'h1
`define ACT_HALT        3'h2
`define ACT_TRAP        3'h3
`define CNT_START       2'h1
`define CNT_STOP        2'h2
`define CNT_TOGGLE      2'h3
`define CFG_HALT_SIGNAL_STATE        3
`define CFG_CNT_LO      4
`define BPI_OTHER       8
`define PSW_CDE         7
`define PSW_GW          8
`define PSW_IS          9
`define PSW_IO_LO       10
`define PSW_PRS_LO      12
`define PSW_IO_MONITOR  2'h2
`define PREV_CONTEXT_LINK_PIE        23
`define PREV_CONTEXT_LINK_PRIOR_CPU_PRIORITY_LO    24
`define SAVE_PREV_CONTEXT_LINK_OFS   32'h0000_0000
`define SAVE_PSW_OFS    32'h0000_0004
`define SAVE_A10_OFS    32'h0000_0008
`define SAVE_A11_OFS    32'h0000_000C
`define EVENT_ORIGIN_TRIG     5'h10
`define DTA_RESET       1'b1
`endif

// [dv/ctx_ram_model.sv]
// Behavioural context save memory that answers the unit's save and restore accesses.
`timescale 1ns/1ps
`default_nettype none
module ctx_ram_model (
   input  wire logic        mclk_i,
   input  wire logic        mem_we_i,
   input  wire logic        mem_re_i,
   input  wire logic [31:0] mem_addr_i,
   input  wire logic [31:0] mem_wdata_i,
   output var  logic [31:0] mem_rdata_o
);
   logic [31:0] ram [4];
   initial mem_rdata_o = 32'h0;
   // Outside a read the data lines toggle, so a sample one cycle late sees the read data inverted.
   always @(posedge mclk_i) begin
      if (mem_we_i) begin
         ram[mem_addr_i[3:2]] <= mem_wdata_i;
      end
      if (mem_re_i) begin
         mem_rdata_o <= ram[mem_addr_i[3:2]];
      end else begin
         mem_rdata_o <= ~mem_rdata_o;
      end
   end
endmodule
`default_nettype wire

// [dv/debug_action_unit_chk.sv]
// Concurrent checks on the ports of the debug action unit.
`timescale 1ns/1ps
`default_nettype none
module debug_action_unit_chk (
   input wire logic        mclk_i,
   input wire logic        rst_b_i,
   input wire logic        hreadyout_o,
   input wire logic        hresp_o,
   input wire logic        monitor_mode_on_i,
   input wire logic        mem_we_o,
   input wire logic        mem_re_o,
   input wire logic [31:0] mem_addr_o,
   input wire logic        ctx_load_o,
   input wire logic        ctx_is_trap_o,
   input wire logic        exec_protect_trap_off_o,
   input wire logic        read_protect_trap_off_o,
   input wire logic        swint_post_o,
   input wire logic        suspend_out_o,
   input wire logic        trap_active_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_b_i);
   a_bus_okay: assert property (hreadyout_o && !hresp_o)
      else $error("bus slave stalled or answered with an error");
   a_reset_dta: assert property (disable iff (1'b0) !rst_b_i |=> trap_active_o)
      else $error("trap active flag not set by reset");
   a_save_burst: assert property ($rose(mem_we_o) |-> mem_we_o [*4] ##1 !mem_we_o)
      else $error("context save is not four consecutive writes");
   a_save_step: assert property (mem_we_o && $past(mem_we_o) |-> mem_addr_o == $past(mem_addr_o) + 32'h4)
      else $error("context save address does not step by one word");
   a_trap_gate: assert property ($rose(mem_we_o) |-> !$past(trap_active_o, 2))
      else $error("trap taken while trap active flag was set");
   a_trap_load: assert property ($rose(mem_we_o) |-> ##3 ctx_load_o && ctx_is_trap_o)
      else $error("trap entry context not loaded with the last save");
   a_ret_burst: assert property ($rose(mem_re_o) |-> mem_re_o [*4] ##1 !mem_re_o ##1 ctx_load_o && !ctx_is_trap_o)
      else $error("monitor return did not restore four words");
   a_ret_clear: assert property ($rose(mem_re_o) |-> !trap_active_o)
      else $error("monitor return left trap active flag set");
   a_emu_fetch: assert property (exec_protect_trap_off_o |-> monitor_mode_on_i)
      else $error("fetch traps relaxed outside debug mode");
   a_emu_data: assert property (read_protect_trap_off_o |-> monitor_mode_on_i)
      else $error("data traps relaxed outside debug mode");
   a_post_hold: assert property (swint_post_o |-> $stable(suspend_out_o))
      else $error("suspend out changed on a posted interrupt");
   c_trap: cover property ($rose(mem_we_o));
   c_return: cover property ($rose(mem_re_o));
   c_post: cover property (swint_post_o);
endmodule
`default_nettype wire

// [dv/test_debug_action_unit.sv]
// Self-checking bench for the debug action unit.
`timescale 1ns/1ps
`default_nettype none
`include "debug_action_defs.vh"
module test_debug_action_unit;
   logic        mclk_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic        monitor_mode_on_i = 1'b1, ext_evt_i = 1'b0, suspend_in_i = 1'b0;
   logic        addr_trig_older_i = 1'b0, csa_entry_access_i = 1'b0, creg_evt_i = 1'b0;
   logic        dbg_instr_i = 1'b0, perf_task_mode_i = 1'b0, global_int_enable_i = 1'b0;
   logic        monitor_return_instr_i = 1'b0;
   logic [1:0]  htrans_i = '0;
   logic [2:0]  hsize_i = '0;
   logic [7:0]  pc_trig_i = '0, addr_trig_i = '0, current_cpu_priority_i = '0;
   logic [31:0] haddr_i = '0, hwdata_i = '0, prev_context_link_i = '0, proc_status_word_i = '0;
   logic [31:0] a10_i = '0, a11_i = '0, pc_i = '0, int_stack_ptr_i = '0, fetch_addr_i = '0;
   logic [31:0] ls_addr_i = '0, r;
   wire logic        hreadyout_o, hresp_o, mem_we_o, mem_re_o, ctx_load_o, ctx_is_trap_o;
   wire logic        exec_protect_trap_off_o, read_protect_trap_off_o, bpi_req_o, swint_post_o;
   wire logic        bpi_other_core_o, suspend_out_o, perf_run_o, halt_o, trap_active_o;
   wire logic [1:0]  bpi_num_o;
   wire logic [7:0]  bpi_prio_o, swint_level_o;
   wire logic [31:0] hrdata_o, mem_rdata_i, mem_addr_o, mem_wdata_o, ctx_prev_context_link_o, ctx_psw_o;
   wire logic [31:0] ctx_a10_o, ctx_a11_o, ctx_pc_o;
   int mismatches = 0, n_compared = 0, n_we = 0, n_bpi = 0, n_sw = 0, n_load = 0;
   logic [7:0]  cfg [4] = '{8'h19, 8'h21, 8'h31, 8'h38};
   logic [31:0] sv [4] = '{32'hAA, 32'h3D85, 32'h1111_0000, 32'h2222_0000};
   always #5 mclk_i = ~mclk_i;
   always @(negedge mclk_i) begin
      if (mem_we_o === 1'b1) n_we++;
      if (bpi_req_o === 1'b1) n_bpi++;
      if (swint_post_o === 1'b1) n_sw++;
      if (ctx_load_o === 1'b1) n_load++;
   end
   debug_action_unit dut (.hready_i(hreadyout_o), .*);
   ctx_ram_model u_ram (.mclk_i, .mem_we_i(mem_we_o), .mem_re_i(mem_re_o),
      .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .mem_rdata_o(mem_rdata_i));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic finish_test;
      if (mismatches == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic hwait;
      int k;
      k = 0;
      @(posedge mclk_i);
      while (hreadyout_o !== 1'b1) begin
         k++;
         if (k > 20) begin
            mismatches++;
            finish_test;
         end
         @(posedge mclk_i);
      end
   endtask
   // One single-word bus transfer; read data lands in r.
   task automatic ahb(input logic w, input logic [15:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hsize_i <= 3'h2;
      hwrite_i <= w;
      haddr_i <= {16'h0, a};
      hwait;
      htrans_i <= 2'h0;
      hsel_i <= 1'b0;
      hwdata_i <= d;
      hwait;
      r = hrdata_o;
   endtask
   task automatic st(input logic [31:0] e);
      ahb(1'b0, `OFS_DBGSTAT, 32'h0);
      chk(r & 32'h1FD0, e);
   endtask
   task automatic ev(input logic [7:0] p, input logic [7:0] a, input logic [1:0] cd);
      @(posedge mclk_i);
      pc_trig_i <= p;
      addr_trig_i <= a;
      {creg_evt_i, dbg_instr_i} <= cd;
      @(posedge mclk_i);
      pc_trig_i <= 8'h0;
      addr_trig_i <= 8'h0;
      {creg_evt_i, dbg_instr_i} <= 2'h0;
      tick(3);
   endtask
   task automatic ret;
      @(posedge mclk_i);
      monitor_return_instr_i <= 1'b1;
      @(posedge mclk_i);
      monitor_return_instr_i <= 1'b0;
      tick(10);
   endtask
   task automatic emu(input logic de, input logic [31:0] f, input logic [31:0] l,
                      input logic [1:0] e);
      @(posedge mclk_i);
      monitor_mode_on_i <= de;
      fetch_addr_i <= f;
      ls_addr_i <= l;
      @(negedge mclk_i);
      chk({exec_protect_trap_off_o, read_protect_trap_off_o}, e);
   endtask
   initial begin
      tick(4);
      rst_b_i <= 1'b1;
      chk(trap_active_o, 1'b1);
      ahb(1'b0, `OFS_TRAP_CTRL, 32'h0);
      chk(r[0], 1'b1);
      ahb(1'b1, 16'hFD20, 32'hFFFF_FFFF);
      ahb(1'b0, 16'hFD20, 32'h0);
      chk(r, 32'h0);
      perf_task_mode_i <= 1'b1;
      for (int i = 0; i < 4; i++) ahb(1'b1, `OFS_TRIG_CFG0 + 16'(8 * i), {24'h0, cfg[i]});
      ahb(1'b1, `OFS_CREG_CFG, 32'h09);
      ahb(1'b1, `OFS_SWDBG_CFG, 32'h01);
      ev(8'h01, 8'h00, 2'h0);
      st(32'h1010);
      chk({suspend_out_o, perf_run_o}, 2'h3);
      ev(8'h03, 8'h00, 2'h0);
      st(32'h1050);
      ev(8'h02, 8'h00, 2'h0);
      st(32'h1140);
      chk({suspend_out_o, perf_run_o}, 2'h0);
      ev(8'h04, 8'h00, 2'h0);
      chk(perf_run_o, 1'b1);
      ev(8'h04, 8'h00, 2'h0);
      st(32'h1200);
      ev(8'h08, 8'h00, 2'h0);
      st(32'h1200);
      chk({suspend_out_o, perf_run_o}, 2'h0);
      ev(8'h00, 8'h00, 2'h3);
      st(32'h0110);
      ev(8'h00, 8'h00, 2'h1);
      st(32'h0240);
      ev(8'h02, 8'h00, 2'h2);
      st(32'h1100);
      addr_trig_older_i <= 1'b1;
      ev(8'h01, 8'h04, 2'h0);
      st(32'h1200);
      csa_entry_access_i <= 1'b1;
      ev(8'h00, 8'h01, 2'h0);
      st(32'h1200);
      csa_entry_access_i <= 1'b0;
      addr_trig_older_i <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         ahb(1'b1, `OFS_BPI_CTRL0 - 16'(4 * i), 32'h10 + i);
         ahb(1'b1, `OFS_TRIG_CFG0 + 16'h30, 32'h4 + i);
         ev(8'h40, 8'h00, 2'h0);
         chk({bpi_num_o, bpi_prio_o, bpi_other_core_o}, {2'(i), 8'(16 + i), 1'b0});
      end
      chk(n_bpi, 4);
      ahb(1'b1, `OFS_BPI_CTRL0 - 16'hC, 32'h113);
      ahb(1'b1, `OFS_TRIG_CFG0 + 16'h30, 32'h0F);
      current_cpu_priority_i <= 8'h20;
      ev(8'h40, 8'h00, 2'h0);
      chk({n_bpi[3:0], bpi_other_core_o, n_sw[3:0]}, 9'h0B0);
      st(32'h1610);
      ahb(1'b1, `OFS_BPI_CTRL0 - 16'hC, 32'h13);
      ahb(1'b1, `OFS_TRIG_CFG0 + 16'h30, 32'h07);
      ev(8'h40, 8'h00, 2'h0);
      chk({n_sw[3:0], swint_level_o}, 12'h113);
      st(32'h1690);
      chk(suspend_out_o, 1'b1);
      ahb(1'b1, `OFS_DBGSTAT, 32'h10);
      st(32'h1610);
      ahb(1'b1, `OFS_MON_ENTRY, 32'h8000_1000);
      ahb(1'b1, `OFS_CTX_SAVE, 32'h9000_0100);
      ahb(1'b1, `OFS_TRAP_CTRL, 32'h0);
      tick(1);
      chk(trap_active_o, 1'b0);
      prev_context_link_i <= sv[0];
      proc_status_word_i <= sv[1];
      a10_i <= sv[2];
      a11_i <= sv[3];
      pc_i <= 32'h3333_0000;
      int_stack_ptr_i <= 32'h4444_0000;
      global_int_enable_i <= 1'b1;
      ahb(1'b1, `OFS_TRIG_CFG0 + 16'h38, 32'h03);
      ev(8'h80, 8'h00, 2'h0);
      tick(4);
      for (int i = 0; i < 4; i++) chk(u_ram.ram[i], sv[i]);
      chk(ctx_pc_o, 32'h8000_1000);
      chk(ctx_a11_o, 32'h3333_0000);
      chk(ctx_a10_o, 32'h4444_0000);
      chk(ctx_prev_context_link_o, 32'h2080_00AA);
      chk(ctx_psw_o, 32'h0000_0A00);
      chk({trap_active_o, ctx_is_trap_o, n_load[3:0]}, 6'h31);
      ev(8'h80, 8'h00, 2'h0);
      tick(4);
      chk(n_we, 4);
      emu(1'b1, 32'h80FF_FFFC, 32'h9012_3456, 2'h3);
      emu(1'b1, 32'h8100_0000, 32'h8F00_0000, 2'h0);
      emu(1'b0, 32'h8000_0000, 32'h9000_0000, 2'h0);
      ret;
      chk({trap_active_o, n_load[3:0]}, 5'h11);
      monitor_mode_on_i <= 1'b1;
      u_ram.ram[3] = 32'h5555_0000;
      ret;
      chk({trap_active_o, ctx_is_trap_o, n_load[3:0]}, 6'h02);
      chk(ctx_pc_o, 32'h5555_0000);
      chk(ctx_a11_o, 32'h5555_0000);
      chk(ctx_psw_o, sv[1]);
      chk(ctx_a10_o, sv[2]);
      suspend_in_i <= 1'b1;
      tick(5);
      @(negedge mclk_i);
      chk(halt_o, 1'b1);
      @(posedge mclk_i);
      suspend_in_i <= 1'b0;
      tick(5);
      @(negedge mclk_i);
      chk(halt_o, 1'b0);
      finish_test;
   end
endmodule
bind debug_action_unit debug_action_unit_chk u_chk (.*);
`default_nettype wire
